// File: verilog/dphy_pkg.sv
`default_nettype none
package dphy_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DQ_W = 16;
    localparam int BEATS = 4;
    localparam int LOCAL_W = DQ_W * BEATS;
    localparam int ADDR_W = 13;
    localparam int CL_W = 3;

    // ------------------------------------------------------------------
    // Timing, counted in interface-clock cycles
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    // Command to pins: 3 half-rate cycles or 6 full-rate cycles, both
    // 6 memory clocks, inside the five-to-seven window.
    localparam logic [3:0] AC_DLY_HALF = 4'h3;
    localparam logic [3:0] AC_DLY_FULL = 4'h6;
    localparam logic [3:0] TAP_MIN = 4'h2;
    localparam logic [3:0] TAP_OFS = 4'h2;
    localparam int PIPE_D = 16;
    localparam int WR_GAP = 2;
    localparam logic [3:0] WR_GAP_T = 4'h2;
    localparam logic [CL_W-1:0] DDR_WL = 3'h1;
    localparam logic [CL_W-1:0] CL_ONE = 3'h1;

    // ------------------------------------------------------------------
    // Pin encodings
    // ------------------------------------------------------------------
    localparam logic CS_IDLE = 1'b1;
    localparam logic [BEATS-1:0] DQS_TOGGLE = 4'h5;
    localparam logic [BEATS-1:0] BEATS_HALF = 4'hf;
    localparam logic [BEATS-1:0] BEATS_FULL = 4'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cs_n;
        logic odt;
    } dphy_cmd_s;

    localparam dphy_cmd_s CMD_NOP = '{addr: '0, ras_n: 1'b1, cas_n: 1'b1,
        we_n: 1'b1, cs_n: 1'b1, odt: 1'b0};

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_GAP = 1'b1
    } dphy_state_e;

endpackage
`default_nettype wire

// File: verilog/dphy_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dphy_if;
    dphy_pkg::dphy_cmd_s cmd;
    logic doing_rd;
    logic doing_wr;
    logic wdata_valid;
    logic [dphy_pkg::LOCAL_W-1:0] wdata;
    logic dqs_burst;
    logic [dphy_pkg::LOCAL_W-1:0] mem_rdata;
    logic mem_rdata_valid;
    logic [dphy_pkg::LOCAL_W-1:0] ctl_rdata;
    logic ctl_rdata_valid;

    modport phy (
        input cmd, doing_rd, doing_wr, wdata_valid, wdata, dqs_burst,
        input ctl_rdata, ctl_rdata_valid,
        output mem_rdata, mem_rdata_valid
    );
    modport ctl (
        output cmd, doing_rd, doing_wr, wdata_valid, wdata, dqs_burst,
        output ctl_rdata, ctl_rdata_valid,
        input mem_rdata, mem_rdata_valid
    );
endinterface
`default_nettype wire

// File: verilog/dphy_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module dphy_ctl (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Physical layer side
    dphy_if.ctl phy,
    // Mode
    input wire logic full_rate,
    // User request
    input wire logic local_rd_req,
    input wire logic local_wr_req,
    input wire logic [dphy_pkg::ADDR_W-1:0] local_addr,
    input wire logic [dphy_pkg::LOCAL_W-1:0] local_wdata,
    output logic local_ready
);

    // ------------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------------
    dphy_pkg::dphy_state_e state, next_state;
    dphy_pkg::dphy_cmd_s next_cmd;
    logic next_doing_rd;
    logic [dphy_pkg::WR_GAP-1:0] wr_dly, next_wr_dly;
    logic [dphy_pkg::LOCAL_W-1:0] wd_dly [dphy_pkg::WR_GAP];
    logic [dphy_pkg::LOCAL_W-1:0] next_wd_dly [dphy_pkg::WR_GAP];
    logic next_doing_wr;
    logic [dphy_pkg::LOCAL_W-1:0] next_wdata;
    logic next_dqs_burst;
    logic take;

    always_comb begin
        take = (state == dphy_pkg::ST_IDLE) && (local_rd_req || local_wr_req);
        next_cmd = dphy_pkg::CMD_NOP;
        next_doing_rd = 1'b0;
        next_state = dphy_pkg::ST_IDLE;
        next_wr_dly = {wr_dly[dphy_pkg::WR_GAP-2:0], 1'b0};
        next_wd_dly[0] = '0;
        for (int i = 1; i < dphy_pkg::WR_GAP; i++) begin
            next_wd_dly[i] = wd_dly[i-1];
        end
        if (take) begin
            next_cmd.addr = local_addr;
            next_cmd.cs_n = 1'b0; // R12
            next_cmd.cas_n = 1'b0;
            if (local_rd_req) begin
                next_doing_rd = 1'b1; // R1 R2
            end else begin
                next_cmd.we_n = 1'b0;
                next_wr_dly[0] = 1'b1; // R18
                next_wd_dly[0] = local_wdata;
            end
            if (full_rate) begin
                next_state = dphy_pkg::ST_GAP; // R11
            end
        end
        // Write valid and write data leave from one flop pair. R14 R15
        next_doing_wr = wr_dly[dphy_pkg::WR_GAP-1];
        next_wdata = wd_dly[dphy_pkg::WR_GAP-1];
        // In full rate the burst strobe trails the write indication by one cycle; in half rate it stays low. R16
        next_dqs_burst = full_rate && phy.doing_wr;
    end

    // Every output below is registered on clk, the interface clock. R17
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= dphy_pkg::ST_IDLE;
            phy.cmd <= dphy_pkg::CMD_NOP;
            phy.doing_rd <= 1'b0;
            wr_dly <= '0;
            for (int i = 0; i < dphy_pkg::WR_GAP; i++) begin
                wd_dly[i] <= '0;
            end
            phy.doing_wr <= 1'b0;
            phy.wdata_valid <= 1'b0;
            phy.wdata <= '0;
            phy.dqs_burst <= 1'b0;
            local_ready <= 1'b0;
        end else begin
            state <= next_state;
            phy.cmd <= next_cmd;
            phy.doing_rd <= next_doing_rd;
            wr_dly <= next_wr_dly;
            wd_dly <= next_wd_dly;
            phy.doing_wr <= next_doing_wr;
            phy.wdata_valid <= next_doing_wr;
            phy.wdata <= next_wdata;
            phy.dqs_burst <= next_dqs_burst;
            local_ready <= (next_state == dphy_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Read data return
    // ------------------------------------------------------------------
    // A stand-in for a correction stage: data and valid share one delay.
    always_ff @(posedge clk) begin
        if (srst) begin
            phy.ctl_rdata <= '0;
            phy.ctl_rdata_valid <= 1'b0;
        end else begin
            phy.ctl_rdata <= phy.mem_rdata; // R9
            phy.ctl_rdata_valid <= phy.mem_rdata_valid; // R9
        end
    end

endmodule // dphy_ctl
`default_nettype wire

// File: verilog/dphy_phy.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Controller pulses doing-read once per read
// R2 - Doing-read rises with its read command
// R3 - Doing-read enables capture and read valid
// R4 - Commands reach pins five to seven clocks later
// R5 - Address and command launch on falling edge
// R6 - Half rate: command two clocks, select one
// R7 - Read capture waits CAS latency after command
// R8 - Read data bypasses controller by default
// R9 - Controller delays read data and valid equally
// R10 - Returned read data forwarded unchanged to user
// R11 - Full rate: each command followed by NOP
// R12 - Full rate: select asserted with command
// R13 - Write valid enables data and strobe drivers
// R14 - Controller times doing-write to write latency
// R15 - Write valid identical to doing-write
// R16 - Burst strobe control only for full rate
// R17 - Controller inputs generated on interface clock
// R18 - Half rate: doing-write two cycles after command
// R19 - Write latency CAS minus one, DDR one
// R20 - Doing-write drives strobe generation, latency aware
// R21 - Write data taken only when valid, held
// R22 - Half rate: word leaves as four beats
// R23 - Interface clock half or equal memory clock
module dphy_phy (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Controller side
    dphy_if.phy ctl,
    // Mode
    input wire logic full_rate,
    input wire logic ddr2,
    input wire logic [dphy_pkg::CL_W-1:0] cas_lat,
    input wire logic rdata_via_ctl,
    // Memory address and command pins
    output logic [dphy_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [1:0] mem_cs_n,
    output logic mem_odt,
    output logic mem_ac_negedge,
    // Memory data pins, one beat per lane
    input wire logic [dphy_pkg::LOCAL_W-1:0] mem_dq_in,
    output logic [dphy_pkg::LOCAL_W-1:0] mem_dq_out,
    output logic [dphy_pkg::BEATS-1:0] mem_dq_oe,
    output logic [dphy_pkg::BEATS-1:0] mem_dqs_out,
    output logic [dphy_pkg::BEATS-1:0] mem_dqs_oe,
    // User read data
    output logic [dphy_pkg::LOCAL_W-1:0] local_rdata,
    output logic local_rdata_valid
);

    // ------------------------------------------------------------------
    // Latency arithmetic
    // ------------------------------------------------------------------
    // Memory clocks to interface cycles; half rate rounds up so that the
    // capture never samples before the data burst has arrived.
    function automatic logic [3:0] to_cyc(input logic full,
                                          input logic [3:0] mclk);
        logic [3:0] r;
        r = full ? mclk : 4'((mclk + 4'h1) >> 1);
        return r;
    endfunction

    function automatic logic [3:0] ac_tap(input logic full);
        logic [3:0] r;
        r = full ? dphy_pkg::AC_DLY_FULL : dphy_pkg::AC_DLY_HALF;
        return r;
    endfunction

    // Taps count the input and output flops, so the pipe index is
    // tap minus two; short taps are clamped to that floor.
    function automatic logic [3:0] tap_idx(input logic [3:0] tap);
        logic [3:0] r;
        r = (tap < dphy_pkg::TAP_MIN) ? 4'h0 : 4'(tap - dphy_pkg::TAP_OFS);
        return r;
    endfunction

    logic [dphy_pkg::CL_W-1:0] wl;
    logic [3:0] ac_i, rd_i, wr_i, wr_tap;

    always_comb begin
        wl = ddr2 ? 3'(cas_lat - dphy_pkg::CL_ONE) : dphy_pkg::DDR_WL; // R19
        ac_i = tap_idx(ac_tap(full_rate)); // R4 R23
        rd_i = tap_idx(4'(ac_tap(full_rate)
            + to_cyc(full_rate, {1'b0, cas_lat}))); // R7
        wr_tap = 4'(ac_tap(full_rate) + to_cyc(full_rate, {1'b0, wl}));
        wr_tap = (wr_tap > dphy_pkg::WR_GAP_T)
            ? 4'(wr_tap - dphy_pkg::WR_GAP_T) : dphy_pkg::TAP_MIN;
        wr_i = tap_idx(wr_tap);
    end

    // ------------------------------------------------------------------
    // Address and command path
    // ------------------------------------------------------------------
    dphy_pkg::dphy_cmd_s ac_pipe [dphy_pkg::PIPE_D];
    dphy_pkg::dphy_cmd_s next_ac_pipe [dphy_pkg::PIPE_D];
    dphy_pkg::dphy_cmd_s ac_sel;

    always_comb begin
        next_ac_pipe[0] = ctl.cmd;
        for (int i = 1; i < dphy_pkg::PIPE_D; i++) begin
            next_ac_pipe[i] = ac_pipe[i-1];
        end
        ac_sel = ac_pipe[ac_i]; // R4
    end

    // The output serialiser launches each word on the falling memory
    // edge so the pins are centred on the rising edge the part samples.
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < dphy_pkg::PIPE_D; i++) begin
                ac_pipe[i] <= dphy_pkg::CMD_NOP;
            end
            mem_addr <= '0;
            mem_ras_n <= 1'b1;
            mem_cas_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_cs_n <= {dphy_pkg::CS_IDLE, dphy_pkg::CS_IDLE};
            mem_odt <= 1'b0;
            mem_ac_negedge <= 1'b0;
        end else begin
            ac_pipe <= next_ac_pipe;
            mem_addr <= ac_sel.addr; // R6
            mem_ras_n <= ac_sel.ras_n; // R6
            mem_cas_n <= ac_sel.cas_n; // R6
            mem_we_n <= ac_sel.we_n; // R6
            mem_cs_n <= {dphy_pkg::CS_IDLE, ac_sel.cs_n}; // R6 R11
            mem_odt <= ac_sel.odt;
            mem_ac_negedge <= 1'b1; // R5
        end
    end

    // ------------------------------------------------------------------
    // Read capture
    // ------------------------------------------------------------------
    logic [dphy_pkg::LOCAL_W-1:0] dq_s1, dq_s2;
    logic [dphy_pkg::PIPE_D-1:0] rd_pipe, next_rd_pipe;
    logic cap_en;
    logic [dphy_pkg::LOCAL_W-1:0] next_cap;
    logic [dphy_pkg::LOCAL_W-1:0] next_local_rdata;
    logic next_local_valid;

    always_comb begin
        next_rd_pipe = {rd_pipe[dphy_pkg::PIPE_D-2:0], ctl.doing_rd}; // R3
        cap_en = rd_pipe[rd_i]; // R3 R7
        next_cap = cap_en ? dq_s2 : ctl.mem_rdata;
        if (rdata_via_ctl) begin
            next_local_rdata = ctl.ctl_rdata; // R10
            next_local_valid = ctl.ctl_rdata_valid; // R10
        end else begin
            next_local_rdata = ctl.mem_rdata; // R8
            next_local_valid = ctl.mem_rdata_valid; // R8
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            rd_pipe <= '0;
            ctl.mem_rdata <= '0;
            ctl.mem_rdata_valid <= 1'b0;
            local_rdata <= '0;
            local_rdata_valid <= 1'b0;
        end else begin
            dq_s1 <= mem_dq_in;
            dq_s2 <= dq_s1;
            rd_pipe <= next_rd_pipe;
            ctl.mem_rdata <= next_cap;
            ctl.mem_rdata_valid <= cap_en; // R3
            local_rdata <= next_local_rdata;
            local_rdata_valid <= next_local_valid;
        end
    end

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    // Each stage takes the word of the stage before it every cycle, so a
    // word moves down the write registers until its memory slot comes.
    logic [dphy_pkg::LOCAL_W-1:0] wd_pipe [dphy_pkg::PIPE_D];
    logic [dphy_pkg::LOCAL_W-1:0] next_wd_pipe [dphy_pkg::PIPE_D];
    logic [dphy_pkg::PIPE_D-1:0] wv_pipe, next_wv_pipe;
    logic [dphy_pkg::PIPE_D-1:0] ws_pipe, next_ws_pipe;
    logic [dphy_pkg::BEATS-1:0] lanes;
    logic [dphy_pkg::BEATS-1:0] next_dq_oe, next_dqs_oe;

    always_comb begin
        next_wd_pipe[0] = ctl.wdata_valid ? ctl.wdata : '0; // R21
        for (int i = 1; i < dphy_pkg::PIPE_D; i++) begin
            next_wd_pipe[i] = wd_pipe[i-1];
        end
        next_wv_pipe = {wv_pipe[dphy_pkg::PIPE_D-2:0], ctl.wdata_valid};
        next_ws_pipe = {ws_pipe[dphy_pkg::PIPE_D-2:0],
            ctl.doing_wr || (full_rate && ctl.dqs_burst)}; // R16
        lanes = full_rate ? dphy_pkg::BEATS_FULL : dphy_pkg::BEATS_HALF;
        next_dq_oe = wv_pipe[wr_i] ? lanes : '0; // R13 R19
        next_dqs_oe = ws_pipe[wr_i] ? lanes : '0; // R20
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < dphy_pkg::PIPE_D; i++) begin
                wd_pipe[i] <= '0;
            end
            wv_pipe <= '0;
            ws_pipe <= '0;
            mem_dq_out <= '0;
            mem_dq_oe <= '0;
            mem_dqs_out <= '0;
            mem_dqs_oe <= '0;
        end else begin
            wd_pipe <= next_wd_pipe;
            wv_pipe <= next_wv_pipe;
            ws_pipe <= next_ws_pipe;
            mem_dq_out <= wd_pipe[wr_i]; // R22
            mem_dq_oe <= next_dq_oe; // R13
            mem_dqs_out <= dphy_pkg::DQS_TOGGLE; // R22
            mem_dqs_oe <= next_dqs_oe; // R20
        end
    end

endmodule // dphy_phy
`default_nettype wire

// File: testbench/dphy_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dphy_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Command and write side
    input wire dphy_pkg::dphy_cmd_s cmd,
    input wire logic doing_rd,
    input wire logic doing_wr,
    input wire logic wdata_valid,
    input wire logic [dphy_pkg::LOCAL_W-1:0] wdata,
    input wire logic dqs_burst,
    // Read return side
    input wire logic [dphy_pkg::LOCAL_W-1:0] mem_rdata,
    input wire logic mem_rdata_valid,
    input wire logic [dphy_pkg::LOCAL_W-1:0] ctl_rdata,
    input wire logic ctl_rdata_valid
);
    logic rd_cmd;
    logic wr_cmd;

    assign rd_cmd = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
    assign wr_cmd = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && !cmd.we_n;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_rd_flag_cmd: assert property (doing_rd |-> rd_cmd)
        else $error("read flag without read command");
    a_rd_cmd_flag: assert property (rd_cmd |-> doing_rd)
        else $error("read command without read flag");
    a_wr_valid_same: assert property (wdata_valid == doing_wr)
        else $error("write valid differs from doing write");
    a_wr_after_cmd: assert property (wr_cmd |-> ##2 doing_wr)
        else $error("doing write not two cycles after write");
    a_wr_has_cmd: assert property (doing_wr |-> $past(wr_cmd, 2))
        else $error("doing write without earlier write command");
    a_ret_valid_delay: assert property (
        ctl_rdata_valid == $past(mem_rdata_valid))
        else $error("returned valid not one cycle late");
    a_ret_data_delay: assert property (
        ctl_rdata_valid |-> ctl_rdata == $past(mem_rdata))
        else $error("returned data not delayed like valid");
    a_burst_follows: assert property (dqs_burst |-> $past(doing_wr))
        else $error("strobe burst without doing write");
    a_wr_data_idle: assert property (!wdata_valid |-> wdata == '0)
        else $error("write data not zero outside valid");
endmodule // dphy_chk
`default_nettype wire

// File: testbench/ddr_phy_controller_handshake_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_phy_controller_handshake_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic full_rate = 1'b0;
    logic ddr2 = 1'b1;
    logic rdata_via_ctl = 1'b0;
    logic [2:0] cas_lat = 3'h3;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [dphy_pkg::ADDR_W-1:0] addr = '0;
    logic [63:0] wdata = '0;
    logic [63:0] dq_in = '0;
    logic local_ready, mem_ras_n, mem_cas_n, mem_we_n, mem_odt;
    logic mem_ac_negedge, local_rdata_valid;
    logic [dphy_pkg::ADDR_W-1:0] mem_addr;
    logic [1:0] mem_cs_n;
    logic [63:0] mem_dq_out, local_rdata;
    logic [3:0] mem_dq_oe, mem_dqs_out, mem_dqs_oe;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    logic [13:0] cmd_q[$];
    int ti_q[$];
    logic [63:0] wd_q[$];
    logic [63:0] rd_q[$];
    logic prev_cs = 1'b0;

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    dphy_if ifc();
    dphy_ctl dphy_ctl_inst (.clk(clk), .srst(srst), .phy(ifc),
        .full_rate(full_rate), .local_rd_req(rd_req), .local_wr_req(wr_req),
        .local_addr(addr), .local_wdata(wdata), .local_ready(local_ready));
    dphy_phy dphy_phy_inst (.clk(clk), .srst(srst), .ctl(ifc),
        .full_rate(full_rate), .ddr2(ddr2), .cas_lat(cas_lat),
        .rdata_via_ctl(rdata_via_ctl), .mem_addr(mem_addr),
        .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
        .mem_cs_n(mem_cs_n), .mem_odt(mem_odt),
        .mem_ac_negedge(mem_ac_negedge), .mem_dq_in(dq_in),
        .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
        .mem_dqs_out(mem_dqs_out), .mem_dqs_oe(mem_dqs_oe),
        .local_rdata(local_rdata), .local_rdata_valid(local_rdata_valid));
    dphy_chk dphy_chk_inst (.clk(clk), .srst(srst), .cmd(ifc.cmd),
        .doing_rd(ifc.doing_rd), .doing_wr(ifc.doing_wr),
        .wdata_valid(ifc.wdata_valid), .wdata(ifc.wdata),
        .dqs_burst(ifc.dqs_burst), .mem_rdata(ifc.mem_rdata),
        .mem_rdata_valid(ifc.mem_rdata_valid), .ctl_rdata(ifc.ctl_rdata),
        .ctl_rdata_valid(ifc.ctl_rdata_valid));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("bad_count %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // The request is held until an edge that sees local_ready high.
    task automatic req(input logic rd);
        int n;
        logic t;
        rd_req = rd;
        wr_req = !rd;
        addr = dphy_pkg::ADDR_W'($urandom);
        wdata = {$urandom, $urandom};
        for (n = 0; n < 50; n++) begin
            t = local_ready;
            @(posedge clk);
            #1;
            if (t) break;
        end
        if (n == 50) begin
            bad_count++;
            close_out();
        end else begin
            cmd_q.push_back({rd, addr});
            if (rd) rd_q.push_back(dq_in);
            else wd_q.push_back(wdata);
        end
    endtask

    task automatic idle_drain;
        int n;
        rd_req = 1'b0;
        wr_req = 1'b0;
        for (n = 0; n < 300; n++) begin
            if (cmd_q.size() + wd_q.size() + rd_q.size() == 0) break;
            @(posedge clk);
        end
        if (n == 300) begin
            bad_count++;
            close_out();
        end else begin
            repeat (4) @(posedge clk);
            #1;
        end
    endtask

    task automatic do_reset(input int cycles);
        srst = 1'b1;
        repeat (cycles) @(posedge clk);
        #1;
        srst = 1'b0;
        cmd_q.delete();
        ti_q.delete();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------------
    // Full rate only carries two beats, so the upper half is masked.
    always @(negedge clk) begin : mon
        logic [13:0] e;
        logic [63:0] m;
        int t;
        m = full_rate ? 64'h0000_0000_ffff_ffff : '1;
        if (!srst) begin
            if (!ifc.cmd.cs_n) ti_q.push_back(cyc);
            if (full_rate && prev_cs) chk(64'(mem_cs_n), 64'h3);
            prev_cs = !mem_cs_n[0];
            if (!mem_cs_n[0]) begin
                e = cmd_q.pop_front();
                t = ti_q.pop_front();
                chk({mem_odt, mem_ras_n, mem_cas_n, mem_cs_n, mem_we_n,
                    mem_addr}, {5'b01010, e});
                chk(64'(cyc - t), full_rate ? 64'(dphy_pkg::AC_DLY_FULL) :
                    64'(dphy_pkg::AC_DLY_HALF));
            end
            if (mem_dq_oe != 4'h0) begin
                chk(mem_dq_out & m, wd_q.pop_front() & m);
                chk({mem_dq_oe, mem_dqs_oe, mem_dqs_out},
                    full_rate ? 12'h335 : 12'hff5);
            end
            if (local_rdata_valid) begin
                chk(local_rdata & m, rd_q.pop_front() & m);
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    // Each mode gets a fresh reset, as modes are not meant to change live.
    initial begin : main
        int i;
        int j;
        int n;
        i = $urandom(29237);
        do_reset(20);
        chk(64'(mem_ac_negedge), 64'h1);
        for (i = 0; i < 6; i++) begin
            full_rate = i[0];
            rdata_via_ctl = i[1];
            ddr2 = (i < 4);
            cas_lat = 3'(3 + i % 3);
            do_reset(3);
            for (j = 0; j < 3; j++) begin
                dq_in = {$urandom, $urandom};
                n = 1 + $urandom % 5;
                repeat (n) req(j == 2 ? 1'($urandom) : (j == 0));
                idle_drain();
            end
        end
        close_out();
    end
endmodule // ddr_phy_controller_handshake_bench
`default_nettype wire
